// file: core/hp_amp_cmd_slave.sv
// two-wire write-only slave with command register for a headphone amplifier
`timescale 1ns/10ps
`default_nettype none
`include "hp_amp_params.svh"
module hp_amp_cmd_slave
	import hp_amp_pkg::*;
(
	// system
	input  wire logic       clk,
	input  wire logic       resetn,
	// two-wire bus
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// device controls
	input  wire logic       addr_select,
	input  wire logic       shutdown_pin_n,
	input  wire logic       supply_lockout,
	// amplifier controls
	output logic            amp_enable,
	output logic            power_enable_bit,
	output logic            bass_boost_enable_bit,
	output logic            bass_feedback_node,
	output logic            signal_ground,
	output logic      [5:0] volume_code,
	output logic      [7:0] atten_half_db
);
	// sampled bus levels
	logic         scl_d_r;
	logic         scl_d_nxt;
	logic         sda_d_r;
	logic         sda_d_nxt;
	// frame machine
	slave_state_t state_r;
	slave_state_t state_nxt;
	logic   [3:0] bit_cnt_r;
	logic   [3:0] bit_cnt_nxt;
	logic   [7:0] shift_r;
	logic   [7:0] shift_nxt;
	logic         rd_r;
	logic         rd_nxt;
	logic         start_pulse_r;
	logic         start_pulse_nxt;
	logic         sda_oe_r;
	logic         sda_oe_nxt;
	// command register
	logic   [7:0] amp_command_r;
	logic   [7:0] amp_command_nxt;
	// amplifier controls
	logic         amp_en_r;
	logic         amp_en_nxt;
	logic         gnd_sw_r;
	logic         gnd_sw_nxt;
	logic   [7:0] atten_r;
	logic   [7:0] atten_nxt;
	logic   [7:0] atten_comb;
	// bus events
	logic         scl_rise;
	logic         scl_fall;
	logic         start_cond;
	logic         stop_cond;
	logic         byte_done;
	logic         cmd_load;

	// low-to-high step between two samples
	function automatic logic level_rise
	(
		input logic now_lvl,
		input logic old_lvl
	);
		return now_lvl & ~old_lvl;
	endfunction

	// high-to-low step between two samples
	function automatic logic level_fall
	(
		input logic now_lvl,
		input logic old_lvl
	);
		return ~now_lvl & old_lvl;
	endfunction

	// msb-first shift of one received bit
	function automatic logic [7:0] shift_bit
	(
		input logic [7:0] cur,
		input logic       din
	);
		return {cur[6:0], din};
	endfunction

	// address byte names this device; r/w bit not compared
	function automatic logic addr_match
	(
		input logic [7:0] addr_byte,
		input logic       sel_b
	);
		logic [6:0] own;
		own = sel_b ? `ADDR_VARIANT_B : `ADDR_VARIANT_A;
		return addr_byte[7:1] == own;
	endfunction

	// amplifier may run only with all three conditions
	function automatic logic run_gate
	(
		input logic [7:0] cmd,
		input logic       pin_n,
		input logic       lockout
	);
		return cmd[`CMD_POWER_BIT] & pin_n & ~lockout;
	endfunction

	assign scl_rise   = level_rise(scl_in, scl_d_r);
	assign scl_fall   = level_fall(scl_in, scl_d_r);
	assign start_cond = scl_in & scl_d_r & level_fall(sda_in, sda_d_r);
	assign stop_cond  = scl_in & scl_d_r & level_rise(sda_in, sda_d_r);
	assign byte_done  = scl_fall & (bit_cnt_r == 4'h8);
	assign cmd_load   = (state_r == ST_DACK) & scl_fall;

	always_comb
	begin
		scl_d_nxt = scl_in;
		sda_d_nxt = sda_in;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			// idle bus is high; no false edge after reset
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_d_r <= scl_d_nxt;
			sda_d_r <= sda_d_nxt;
		end
	end

	always_comb
	begin
		state_nxt       = state_r;
		bit_cnt_nxt     = bit_cnt_r;
		shift_nxt       = shift_r;
		rd_nxt          = rd_r;
		sda_oe_nxt      = sda_oe_r;
		start_pulse_nxt = start_pulse_r;
		if (scl_fall)
			start_pulse_nxt = 1'b0;
		if (start_cond)
		begin
			// start or repeated start opens a frame
			state_nxt       = ST_ADDR;
			bit_cnt_nxt     = 4'h0;
			sda_oe_nxt      = 1'b0;
			start_pulse_nxt = 1'b1;
		end
		else if (stop_cond && !start_pulse_r)
		begin
			// abort in any state, except before scl first falls after a start; partial byte discarded
			state_nxt  = ST_IDLE;
			sda_oe_nxt = 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE, ST_IGNORE:
					sda_oe_nxt = 1'b0;
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						shift_nxt   = shift_bit(shift_r, sda_in);
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end
					if (byte_done)
					begin
						bit_cnt_nxt = 4'h0;
						if (addr_match(shift_r, addr_select))
						begin
							// ack even for read requests
							rd_nxt     = shift_r[0];
							sda_oe_nxt = 1'b1;
							state_nxt  = ST_AACK;
						end
						else
							state_nxt = ST_IGNORE;
					end
				end
				ST_AACK:
					if (scl_fall)
					begin
						sda_oe_nxt = 1'b0;
						// read: never drive, master sees ones
						state_nxt  = rd_r ? ST_IGNORE : ST_DATA;
					end
				ST_DATA:
				begin
					if (scl_rise)
					begin
						shift_nxt   = shift_bit(shift_r, sda_in);
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end
					if (byte_done)
					begin
						bit_cnt_nxt = 4'h0;
						sda_oe_nxt  = 1'b1;
						state_nxt   = ST_DACK;
					end
				end
				ST_DACK:
					if (scl_fall)
					begin
						// later bytes of the frame are not acked
						sda_oe_nxt = 1'b0;
						state_nxt  = ST_IGNORE;
					end
				default:
					state_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_r       <= ST_IDLE;
			bit_cnt_r     <= 4'h0;
			shift_r       <= 8'h00;
			rd_r          <= 1'b0;
			start_pulse_r <= 1'b0;
			sda_oe_r      <= 1'b0;
		end
		else
		begin
			state_r       <= state_nxt;
			bit_cnt_r     <= bit_cnt_nxt;
			shift_r       <= shift_nxt;
			rd_r          <= rd_nxt;
			start_pulse_r <= start_pulse_nxt;
			sda_oe_r      <= sda_oe_nxt;
		end
	end

	always_comb
	begin
		amp_command_nxt = amp_command_r;
		// one byte per frame, loaded at the end of its ack
		if (cmd_load)
			amp_command_nxt = shift_r;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			amp_command_r <= `CMD_RESET_VALUE;
		else
			amp_command_r <= amp_command_nxt;
	end

	vol_atten_map u_vol_map
	(
		.vol_code      (amp_command_r[`CMD_VOL_MSB:`CMD_VOL_LSB]),
		.atten_half_db (atten_comb)
	);

	always_comb
	begin
		// shutdown never touches bus or register
		amp_en_nxt = run_gate(amp_command_r, shutdown_pin_n,
			supply_lockout);
		gnd_sw_nxt = ~amp_command_nxt[`CMD_BASS_BIT];
		atten_nxt  = atten_comb;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			amp_en_r <= 1'b0;
			gnd_sw_r <= 1'b0;
			atten_r  <= 8'h00;
		end
		else
		begin
			amp_en_r <= amp_en_nxt;
			gnd_sw_r <= gnd_sw_nxt;
			atten_r  <= atten_nxt;
		end
	end

	assign sda_out               = 1'b0;
	assign sda_oe                = sda_oe_r;
	assign amp_enable            = amp_en_r;
	assign power_enable_bit      = amp_command_r[`CMD_POWER_BIT];
	assign bass_boost_enable_bit = amp_command_r[`CMD_BASS_BIT];
	assign bass_feedback_node    = amp_command_r[`CMD_BASS_BIT];
	assign signal_ground         = gnd_sw_r;
	assign volume_code           = amp_command_r[`CMD_VOL_MSB:`CMD_VOL_LSB];
	assign atten_half_db         = atten_r;
endmodule
`default_nettype wire

// file: core/hp_amp_params.svh
// constants for the headphone amplifier command interface
`ifndef HP_AMP_PARAMS_SVH
`define HP_AMP_PARAMS_SVH
`define ADDR_VARIANT_A 7'h4C
`define ADDR_VARIANT_B 7'h4D
`define CMD_RESET_VALUE 8'hFF
`define CMD_POWER_BIT 7
`define CMD_BASS_BIT 6
`define CMD_VOL_MSB 5
`define CMD_VOL_LSB 0
`define VOL_STEP4_LAST 6'h0E
`define VOL_STEP2_LAST 6'h1F
`define VOL_STEP1_LAST 6'h39
`endif

// file: core/hp_amp_pkg.sv
// types for the headphone amplifier command interface
package hp_amp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_DATA = 3'b011,
		ST_DACK = 3'b100,
		ST_IGNORE = 3'b101
	} slave_state_t;
	// attenuation in half-dB units, 0..240
	typedef logic [7:0] half_db_t;
endpackage

// file: core/vol_atten_map.sv
// volume code to attenuation in half-dB units
`timescale 1ns/10ps
`default_nettype none
`include "hp_amp_params.svh"
module vol_atten_map
	import hp_amp_pkg::*;
(
	// code in
	input  wire logic [5:0] vol_code,
	// attenuation out
	output logic      [7:0] atten_half_db
);
	always_comb
	begin
		if (vol_code <= `VOL_STEP4_LAST)
			atten_half_db = 8'hF0 - {vol_code[4:0], 3'b000};
		else if (vol_code <= `VOL_STEP2_LAST)
			atten_half_db = 8'hB8 - {vol_code[5:0], 2'b00};
		else if (vol_code <= `VOL_STEP1_LAST)
			atten_half_db = 8'h78 - {1'b0, vol_code, 1'b0};
		else
			atten_half_db = 8'h3F - {2'b00, vol_code};
	end
endmodule
`default_nettype wire

// file: testbench/bus_master.sv
// two-wire bus master model
`timescale 1ns/10ps
`default_nettype none
module bus_master(
	// bus
	input  wire logic clk,
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bit9(input logic b, output logic s);
		w(1);
		sda_m <= b;
		w(4);
		scl <= 1'b1;
		w(4);
		s = sda;
		scl <= 1'b0;
	endtask
	// msb first, ninth bit released for ack
	task automatic xfer(input logic [7:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
			bit9(i > 0 ? d[i-1] : 1'b1, r[i]);
	endtask
	task automatic start;
		w(1);
		sda_m <= 1'b1;
		w(3);
		scl <= 1'b1;
		w(4);
		sda_m <= 1'b0;
		w(4);
		scl <= 1'b0;
	endtask
	task automatic stop;
		w(1);
		sda_m <= 1'b0;
		w(4);
		scl <= 1'b1;
		w(4);
		sda_m <= 1'b1;
		w(4);
	endtask
endmodule
`default_nettype wire

// file: testbench/headphone_amp_i2c_cmd_reg_tb.sv
// testbench for the command slave
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module headphone_amp_i2c_cmd_reg_tb;
	logic clk, resetn, addr_select, shutdown_pin_n, supply_lockout;
	logic scl_in, sda_m, sda_out, sda_oe, amp_enable, power_enable_bit;
	logic bass_boost_enable_bit, bass_feedback_node, signal_ground;
	logic [5:0] volume_code;
	logic [7:0] atten_half_db;
	logic [8:0] r;
	int   n_tests = 0, bad_count = 0;
	wire logic sda_in = sda_m & ~(sda_oe & ~sda_out);
	always #20 clk = ~clk;
	hp_amp_cmd_slave dut
	(
		.clk                   (clk),
		.resetn                (resetn),
		.scl_in                (scl_in),
		.sda_in                (sda_in),
		.sda_out               (sda_out),
		.sda_oe                (sda_oe),
		.addr_select           (addr_select),
		.shutdown_pin_n        (shutdown_pin_n),
		.supply_lockout        (supply_lockout),
		.amp_enable            (amp_enable),
		.power_enable_bit      (power_enable_bit),
		.bass_boost_enable_bit (bass_boost_enable_bit),
		.bass_feedback_node    (bass_feedback_node),
		.signal_ground         (signal_ground),
		.volume_code           (volume_code),
		.atten_half_db         (atten_half_db)
	);
	bus_master m(.clk(clk), .scl(scl_in), .sda_m(sda_m), .sda(sda_in));
	function automatic logic [7:0] att(input logic [5:0] v);
		if (v <= 6'h0E) return 8'hF0 - 8'(v) * 8'h08;
		if (v <= 6'h1F) return 8'h7C - (8'(v) - 8'h0F) * 8'h04;
		if (v <= 6'h39) return 8'h38 - (8'(v) - 8'h20) * 8'h02;
		return 8'h3F - 8'(v);
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		m.start();
		m.xfer(a, r);
		`CHK("addr ack", 1'b0, r[0])
		m.xfer(d, r);
		`CHK("data ack", 1'b0, r[0])
		m.stop();
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		addr_select = 1'b0;
		shutdown_pin_n = 1'b1;
		supply_lockout = 1'b0;
		m.w(5);
		resetn <= 1'b1;
		m.w(3);
		`CHK("por", 8'hFF, {power_enable_bit, bass_boost_enable_bit, volume_code})
		`CHK("por run", 1'b1, amp_enable)
		for (int i = 0; i < 64; i++)
		begin
			wr(8'h98, 8'h80 | 8'(i));
			`CHK("atten", att(6'(i)), atten_half_db)
		end
		`CHK("ground", 1'b1, signal_ground)
		$display("volume test done");
		shutdown_pin_n <= 1'b0;
		wr(8'h98, 8'hC0);
		`CHK("pin off", 1'b0, amp_enable)
		`CHK("mute", 8'hF0, atten_half_db)
		`CHK("bass", 1'b1, bass_feedback_node)
		shutdown_pin_n <= 1'b1;
		supply_lockout <= 1'b1;
		m.w(3);
		`CHK("lockout", 1'b0, amp_enable)
		supply_lockout <= 1'b0;
		m.w(3);
		`CHK("wake", 1'b1, amp_enable)
		wr(8'h98, 8'h15);
		`CHK("bit off", 1'b0, amp_enable)
		m.start();
		m.xfer(8'h9A, r);
		`CHK("nack", 1'b1, r[0])
		m.xfer(8'h3F, r);
		m.start();
		m.xfer(8'h99, r);
		`CHK("read ack", 1'b0, r[0])
		m.xfer(8'hFF, r);
		`CHK("read ones", 9'h1FF, r)
		m.start();
		m.xfer(8'h98, r);
		m.bit9(1'b1, r[0]);
		m.bit9(1'b1, r[0]);
		m.stop();
		`CHK("kept", 6'h15, volume_code)
		addr_select <= 1'b1;
		wr(8'h9A, 8'hBA);
		`CHK("variant", 8'h05, atten_half_db)
		$display("control test done");
		resetn <= 1'b0;
		m.w(5);
		resetn <= 1'b1;
		m.w(3);
		`CHK("reset", 6'h3F, volume_code)
		`CHK("reset gnd", 1'b0, signal_ground)
		$display("reset test done");
		test_done();
	end
endmodule
`default_nettype wire

// file: testbench/hp_amp_cmd_sva.sv
// assertions on the command slave ports
`timescale 1ns/10ps
`default_nettype none
module hp_amp_cmd_sva(
	// system and bus
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// controls and outputs
	input wire logic       shutdown_pin_n,
	input wire logic       supply_lockout,
	input wire logic       amp_enable,
	input wire logic       power_enable_bit,
	input wire logic       bass_boost_enable_bit,
	input wire logic       bass_feedback_node,
	input wire logic       signal_ground,
	input wire logic [5:0] volume_code,
	input wire logic [7:0] atten_half_db
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence ack_high;
		sda_oe && scl_in;
	endsequence
	a_reset_value:
	assert property ($rose(resetn) |-> power_enable_bit && bass_boost_enable_bit
		&& &volume_code) else $error("reset value wrong");
	a_amp_gate:
	assert property ($past(resetn) |-> amp_enable ==
		$past(power_enable_bit && shutdown_pin_n && !supply_lockout)) else $error("enable wrong");
	a_bass_pair:
	assert property (bass_feedback_node == bass_boost_enable_bit
		&& signal_ground != bass_boost_enable_bit) else $error("bass path wrong");
	a_mute_atten:
	assert property ($past(resetn) && $past(volume_code) == 6'h00 |->
		atten_half_db == 8'hF0) else $error("mute wrong");
	a_half_step:
	assert property ($past(resetn) && $past(volume_code) == 6'h3A |->
		atten_half_db == 8'h05) else $error("half step wrong");
	a_ack_stable:
	assert property (ack_high |=> sda_oe) else $error("ack dropped");
	a_drain_low:
	assert property (!sda_out) else $error("data driven high");
	a_load_after_ack:
	assert property ($past(resetn) && $changed(volume_code) |-> $past(sda_oe, 2))
		else $error("load without ack");
endmodule
bind hp_amp_cmd_slave hp_amp_cmd_sva chk
(
	.clk                   (clk),
	.resetn                (resetn),
	.scl_in                (scl_in),
	.sda_out               (sda_out),
	.sda_oe                (sda_oe),
	.shutdown_pin_n        (shutdown_pin_n),
	.supply_lockout        (supply_lockout),
	.amp_enable            (amp_enable),
	.power_enable_bit      (power_enable_bit),
	.bass_boost_enable_bit (bass_boost_enable_bit),
	.bass_feedback_node    (bass_feedback_node),
	.signal_ground         (signal_ground),
	.volume_code           (volume_code),
	.atten_half_db         (atten_half_db)
);
`default_nettype wire
